// ===== hw/aaf_params.svh
// offsets, field positions, reset values for the accumulator alu
`ifndef AAF_PARAMS_SVH
`define AAF_PARAMS_SVH
`define AAF_OFS_SEL      8'h00
`define AAF_OFS_CTRL     8'h04
`define AAF_OFS_STATUS   8'h08
`define AAF_ACC_REGION   2'h1
`define AAF_BIT_EQUALS   0
`define AAF_BIT_CARRY    1
`define AAF_BIT_SIGN     6
`define AAF_BIT_ZERO     7
`define AAF_BIT_DIR      6
`define AAF_SEL_RST      4'h0
`define AAF_MOD_RST      3'h0
`define AAF_DIR_RST      1'h0
`define AAF_ACC_RST      16'h0000
`define AAF_FLAG_RST     1'h0
`define AAF_ZERO_RST     1'h1
`define AAF_MOD_NONE     3'h0
`define AAF_MOD_2        3'h1
`define AAF_MOD_4        3'h2
`define AAF_MOD_8        3'h3
`define AAF_MOD_16       3'h4
`endif

// ===== hw/aaf_pkg.sv
// operation and branch condition types for the accumulator alu
package aaf_pkg;
  typedef enum logic [5:0] {
    OP_NOP                 = 6'b000000,
    OP_ADD                 = 6'b000001,
    OP_ADDC                = 6'b000010,
    OP_SUB                 = 6'b000011,
    OP_SUBB                = 6'b000100,
    OP_CMP                 = 6'b000101,
    OP_AND                 = 6'b000110,
    OP_OR                  = 6'b000111,
    OP_XOR                 = 6'b001000,
    OP_CPL                 = 6'b001001,
    OP_NEG                 = 6'b001010,
    OP_RL                  = 6'b001011,
    OP_RLC                 = 6'b001100,
    OP_RR                  = 6'b001101,
    OP_RRC                 = 6'b001110,
    OP_SLA                 = 6'b001111,
    OP_SLA2                = 6'b010000,
    OP_SLA4                = 6'b010001,
    OP_SRA                 = 6'b010010,
    OP_SRA2                = 6'b010011,
    OP_SRA4                = 6'b010100,
    OP_LOGICAL_SHIFT_RIGHT = 6'b010101,
    OP_XCHN                = 6'b010110,
    OP_XCH                 = 6'b010111,
    OP_MOV_TO_ACC          = 6'b011000,
    OP_MOV_FROM_ACC        = 6'b011001,
    OP_MOV_FROM_ACC_IDX    = 6'b011010,
    OP_BIT_TO_C            = 6'b011011,
    OP_C_TO_BIT            = 6'b011100,
    OP_BIT_AND             = 6'b011101,
    OP_BIT_OR              = 6'b011110,
    OP_BIT_XOR             = 6'b011111,
    OP_LOAD_C              = 6'b100000,
    OP_CPL_C               = 6'b100001,
    OP_STATUS_WR           = 6'b100010
  } aaf_op_t;
  typedef enum logic [2:0] {
    CND_C  = 3'b000,
    CND_NC = 3'b001,
    CND_Z  = 3'b010,
    CND_NZ = 3'b011,
    CND_S  = 3'b100,
    CND_E  = 3'b101,
    CND_NE = 3'b110
  } aaf_cond_t;
endpackage : aaf_pkg

// ===== hw/aaf_step_if.sv
// interface between the alu and its selector stepper
`timescale 1ns/1ns
`default_nettype none
interface aaf_step_if;
  logic [3:0] accumulator_selector;
  logic [2:0] modulo_sel;
  logic       step_direction_bit;
  logic [3:0] next_selector;
  modport user    (output accumulator_selector, output modulo_sel, output step_direction_bit,
                   input next_selector);
  modport stepper (input accumulator_selector, input modulo_sel, input step_direction_bit,
                   output next_selector);
endinterface : aaf_step_if
`default_nettype wire

// ===== hw/aaf_stepper.sv
// modulo increment or decrement of the accumulator selector
`timescale 1ns/1ns
`default_nettype none
`include "aaf_params.svh"
module aaf_stepper
  import aaf_pkg::*;
(
  aaf_step_if.stepper st
);
  logic [3:0] mask;
  logic [3:0] moved;

  always_comb begin
    unique case (st.modulo_sel)
      `AAF_MOD_2:  mask = 4'h1;
      `AAF_MOD_4:  mask = 4'h3;
      `AAF_MOD_8:  mask = 4'h7;
      `AAF_MOD_16: mask = 4'hf;
      default:     mask = 4'h0;
    endcase
    moved = st.step_direction_bit ? st.accumulator_selector - 4'h1 : st.accumulator_selector + 4'h1;
    // wrap inside the field, bits above it untouched
    st.next_selector = (st.accumulator_selector & ~mask) | (moved & mask);
  end
endmodule : aaf_stepper
`default_nettype wire

// ===== hw/aaf_alu.sv
// accumulator alu with sixteen accumulators, selector stepping and status flags
`timescale 1ns/1ns
`default_nettype none
`include "aaf_params.svh"
module aaf_alu
  import aaf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        op_valid,
  input  wire aaf_op_t     op_code,
  input  wire logic [15:0] op_src,
  input  wire logic        op_src_is_acc,
  input  wire logic [3:0]  op_bit,
  input  wire logic        op_imm_bit,
  input  wire aaf_cond_t   cond_sel,
  input  wire logic        cond_target_imm,
  output logic             cond_met,
  output logic             op_error,
  output logic [15:0]      active_acc,
  output logic [3:0]       accumulator_selector,
  output logic             sign_flag,
  output logic             zero_flag,
  output logic             carry_flag,
  output logic             equals_flag
);
  logic [15:0] acc_q [16];
  logic [3:0]  sel_q, sel_d;
  logic [2:0]  mod_q;
  logic        dir_q;
  logic        carry_q, carry_d, equals_q, equals_d;
  logic        sign_q, zero_q, cond_q, err_q, wait_q;
  logic [15:0] act_q;
  logic [31:0] rdata_q;
  logic [15:0] act, res, wr_val, act_next, bmask, status_word;
  logic [16:0] wide;
  logic [3:0]  wr_idx;
  logic        we, wr_en, step, err, src_op, bitv, acc_op;
  logic        bus_go, bus_wr, hit_sel, hit_ctrl, hit_stat, hit_acc;

  aaf_step_if st ();
  aaf_stepper u_stepper (.st(st));

  assign st.accumulator_selector = sel_q;
  assign st.modulo_sel           = mod_q;
  assign st.step_direction_bit   = dir_q;

  assign act = acc_q[sel_q];
  assign bitv = act[op_bit];
  assign src_op = op_code inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_CMP, OP_AND, OP_OR, OP_XOR};
  // ops that write the accumulator and then step the selector
  assign acc_op = op_code inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_OR, OP_XOR, OP_CPL, OP_NEG,
                                  OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SLA, OP_SLA2, OP_SLA4, OP_SRA, OP_SRA2, OP_SRA4,
                                  OP_LOGICAL_SHIFT_RIGHT, OP_XCHN, OP_XCH, OP_MOV_TO_ACC};

  // bus decode; an operation holds the bus off for that cycle
  assign bus_go   = (avs_read | avs_write) & wait_q & ~op_valid;
  assign bus_wr   = bus_go & avs_write;
  assign hit_sel  = avs_address == `AAF_OFS_SEL;
  assign hit_ctrl = avs_address == `AAF_OFS_CTRL;
  assign hit_stat = avs_address == `AAF_OFS_STATUS;
  assign hit_acc  = (avs_address[7:6] == `AAF_ACC_REGION) & (avs_address[1:0] == 2'h0);
  assign bmask    = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign status_word = {8'h00, zero_q, sign_q, 4'h0, carry_q, equals_q};

  // operation datapath
  always_comb begin
    res      = act;
    we       = 1'b0;
    carry_d  = carry_q;
    equals_d = equals_q;
    step     = 1'b0;
    err      = 1'b0;
    wide     = 17'h0_0000;
    if (op_valid && src_op && op_src_is_acc) begin
      err = 1'b1;
    end else if (op_valid) begin
      we   = acc_op;
      step = acc_op;
      unique case (op_code)
        OP_ADD: begin
          wide = {1'b0, act} + {1'b0, op_src};
          {carry_d, res} = wide;
        end
        OP_ADDC: begin
          wide = {1'b0, act} + {1'b0, op_src} + {16'h0000, carry_q};
          {carry_d, res} = wide;
        end
        OP_SUB: begin
          wide = {1'b0, act} - {1'b0, op_src};
          {carry_d, res} = wide;
        end
        OP_SUBB: begin
          wide = {1'b0, act} - {1'b0, op_src} - {16'h0000, carry_q};
          {carry_d, res} = wide;
        end
        OP_CMP: equals_d = (op_src == act);
        OP_AND: begin
          res = act & op_src;
        end
        OP_OR: begin
          res = act | op_src;
        end
        OP_XOR: begin
          res = act ^ op_src;
        end
        OP_CPL: begin
          res = ~act;
        end
        OP_NEG: begin
          res = ~act + 16'h0001;
        end
        OP_RL: begin
          res = {act[14:0], act[15]};
        end
        OP_RLC: begin
          {carry_d, res} = {act, carry_q};
        end
        OP_RR: begin
          res = {act[0], act[15:1]};
        end
        OP_RRC: begin
          {res, carry_d} = {carry_q, act};
        end
        OP_SLA: begin
          {carry_d, res} = {act, 1'b0};
        end
        OP_SLA2: begin
          carry_d = act[14];
          res = {act[13:0], 2'h0};
        end
        OP_SLA4: begin
          carry_d = act[12];
          res = {act[11:0], 4'h0};
        end
        OP_SRA: begin
          carry_d = act[0];
          res = {act[15], act[15:1]};
        end
        OP_SRA2: begin
          carry_d = act[1];
          res = {{2{act[15]}}, act[15:2]};
        end
        OP_SRA4: begin
          carry_d = act[3];
          res = {{4{act[15]}}, act[15:4]};
        end
        OP_LOGICAL_SHIFT_RIGHT: begin
          carry_d = act[0];
          res = {1'b0, act[15:1]};
        end
        OP_XCHN: begin
          res = {act[11:8], act[15:12], act[3:0], act[7:4]};
        end
        OP_XCH: begin
          res = {act[7:0], act[15:8]};
        end
        OP_MOV_TO_ACC: begin
          res = op_src;
        end
        OP_MOV_FROM_ACC: step = 1'b1;
        OP_MOV_FROM_ACC_IDX: step = 1'b0;
        OP_BIT_TO_C: carry_d = bitv;
        OP_C_TO_BIT: begin
          res[op_bit] = carry_q;
          we = 1'b1;
        end
        OP_BIT_AND: carry_d = carry_q & bitv;
        OP_BIT_OR:  carry_d = carry_q | bitv;
        OP_BIT_XOR: carry_d = carry_q ^ bitv;
        OP_LOAD_C:  carry_d = op_imm_bit;
        OP_CPL_C:   carry_d = ~carry_q;
        OP_STATUS_WR: begin
          equals_d = op_src[`AAF_BIT_EQUALS];
          carry_d  = op_src[`AAF_BIT_CARRY];
        end
        default: res = act;
      endcase
    end else if (bus_wr && hit_stat && avs_byteenable[0]) begin
      equals_d = avs_writedata[`AAF_BIT_EQUALS];
      carry_d  = avs_writedata[`AAF_BIT_CARRY];
    end
  end

  // one write port: operation result into the starting accumulator, else bus
  always_comb begin
    wr_en  = we | (bus_wr & hit_acc);
    wr_idx = we ? sel_q : avs_address[5:2];
    wr_val = we ? res : ((acc_q[avs_address[5:2]] & ~bmask) | (avs_writedata[15:0] & bmask));
    if (step) begin
      sel_d = st.next_selector;
    end else if (bus_wr && hit_sel && avs_byteenable[0]) begin
      sel_d = avs_writedata[3:0];
    end else begin
      sel_d = sel_q;
    end
    act_next = (wr_en && wr_idx == sel_d) ? wr_val : acc_q[sel_d];
  end

  for (genvar i = 0; i < 16; i++) begin : g_acc
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        acc_q[i] <= `AAF_ACC_RST;
      end else if (wr_en && wr_idx == 4'(i)) begin
        acc_q[i] <= wr_val;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_q <= `AAF_SEL_RST;
    end else begin
      sel_q <= sel_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mod_q <= `AAF_MOD_RST;
      dir_q <= `AAF_DIR_RST;
    end else if (bus_wr && hit_ctrl && avs_byteenable[0]) begin
      mod_q <= avs_writedata[2:0];
      dir_q <= avs_writedata[`AAF_BIT_DIR];
    end
  end

  // flags: sign and zero follow the next active accumulator
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      carry_q  <= `AAF_FLAG_RST;
      equals_q <= `AAF_FLAG_RST;
      sign_q   <= `AAF_FLAG_RST;
      zero_q   <= `AAF_ZERO_RST;
      act_q    <= `AAF_ACC_RST;
      err_q    <= `AAF_FLAG_RST;
    end else begin
      carry_q  <= carry_d;
      equals_q <= equals_d;
      sign_q   <= act_next[15];
      zero_q   <= act_next == 16'h0000;
      act_q    <= act_next;
      err_q    <= err;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cond_q <= 1'b0;
    end else begin
      unique case (cond_sel)
        CND_C:   cond_q <= carry_q;
        CND_NC:  cond_q <= ~carry_q;
        CND_Z:   cond_q <= zero_q;
        CND_NZ:  cond_q <= ~zero_q;
        CND_S:   cond_q <= sign_q;
        CND_E:   cond_q <= equals_q & cond_target_imm;
        CND_NE:  cond_q <= ~equals_q & cond_target_imm;
        default: cond_q <= 1'b0;
      endcase
    end
  end

  // avalon slave: one wait cycle, then waitrequest low for one cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (bus_go) begin
      wait_q <= 1'b0;
      if (hit_sel) begin
        rdata_q <= {28'h000_0000, sel_q};
      end else if (hit_ctrl) begin
        rdata_q <= {25'h000_0000, dir_q, 3'h0, mod_q};
      end else if (hit_stat) begin
        rdata_q <= {16'h0000, status_word};
      end else if (hit_acc) begin
        rdata_q <= {16'h0000, acc_q[avs_address[5:2]]};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign avs_readdata         = rdata_q;
  assign avs_waitrequest      = wait_q;
  assign cond_met             = cond_q;
  assign op_error             = err_q;
  assign active_acc           = act_q;
  assign accumulator_selector = sel_q;
  assign sign_flag            = sign_q;
  assign zero_flag            = zero_q;
  assign carry_flag           = carry_q;
  assign equals_flag          = equals_q;

  AST_STEP_FIELD: assert property (@(posedge mclk) disable iff (rst)
    (step && mod_q == `AAF_MOD_2) |=> sel_q[3:1] == $past(sel_q[3:1]) && sel_q[0] != $past(sel_q[0]))
    else $error("mod 2 step left upper selector bits wrong");
  AST_SRC_REFUSED: assert property (@(posedge mclk) disable iff (rst)
    (op_valid && src_op && op_src_is_acc) |=> op_error && $stable(sel_q) && $stable(carry_q) && $stable(act_q))
    else $error("accumulator used as source was not refused");
  AST_ADD_RESULT: assert property (@(posedge mclk) disable iff (rst)
    (op_valid && op_code == OP_ADD && !op_src_is_acc)
      |=> {carry_q, acc_q[$past(sel_q)]} == {1'b0, $past(act)} + {1'b0, $past(op_src)})
    else $error("add result or carry wrong");
  AST_CMP_EQUALS: assert property (@(posedge mclk) disable iff (rst)
    (op_valid && op_code == OP_CMP && !op_src_is_acc)
      |=> equals_q == ($past(op_src) == $past(act)) && acc_q[$past(sel_q)] == $past(act))
    else $error("compare flag wrong or accumulator changed");
  AST_NEG_RESULT: assert property (@(posedge mclk) disable iff (rst)
    (op_valid && op_code == OP_NEG) |=> acc_q[$past(sel_q)] == 16'h0000 - $past(act))
    else $error("negate result wrong");
  AST_LSR: assert property (@(posedge mclk) disable iff (rst)
    (op_valid && op_code == OP_LOGICAL_SHIFT_RIGHT)
      |=> !acc_q[$past(sel_q)][15] && carry_q == $past(act[0]) && acc_q[$past(sel_q)][14:0] == $past(act[15:1]))
    else $error("logical right shift wrong");
  AST_XCH: assert property (@(posedge mclk) disable iff (rst)
    (op_valid && op_code == OP_XCH) |=> acc_q[$past(sel_q)] == {$past(act[7:0]), $past(act[15:8])})
    else $error("byte swap wrong");
  AST_BIT_NO_STEP: assert property (@(posedge mclk) disable iff (rst)
    (op_valid && op_code inside {OP_BIT_TO_C, OP_C_TO_BIT, OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR})
      |=> $stable(sel_q))
    else $error("bit operation moved the selector");
  AST_SIGN: assert property (@(posedge mclk) disable iff (rst)
    sign_flag == acc_q[sel_q][15])
    else $error("sign flag does not mirror active msb");
  AST_ZERO: assert property (@(posedge mclk) disable iff (rst)
    zero_flag == (acc_q[sel_q] == 16'h0000))
    else $error("zero flag does not match active accumulator");
endmodule : aaf_alu
`default_nettype wire

// ===== tb/aaf_dec_model.sv
// decoder model that issues operations and branch queries to the alu
`timescale 1ns/1ns
`default_nettype none
module aaf_dec_model
  import aaf_pkg::*;
(
  input  wire logic   mclk,
  output logic        op_valid,
  output var aaf_op_t op_code,
  output logic [15:0] op_src,
  output logic        op_src_is_acc,
  output logic [3:0]  op_bit,
  output logic        op_imm_bit,
  output var aaf_cond_t cond_sel,
  output logic        cond_target_imm
);
  initial begin
    op_valid = 1'b0;
    op_code = OP_NOP;
    op_src = 16'h0000;
    op_src_is_acc = 1'b0;
    op_bit = 4'h0;
    op_imm_bit = 1'b0;
    cond_sel = CND_C;
    cond_target_imm = 1'b1;
  end
  // one-cycle strobe; the accumulator-as-source flag is only set to provoke a refusal
  task automatic issue(input aaf_op_t c, input logic [15:0] s, input logic a, input logic [3:0] b, input logic i);
    @(posedge mclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_src <= s;
    op_src_is_acc <= a;
    op_bit <= b;
    op_imm_bit <= i;
    @(posedge mclk);
    op_valid <= 1'b0;
    op_src <= ~s;
  endtask : issue
  task automatic branch(input aaf_cond_t c, input logic i);
    @(posedge mclk);
    cond_sel <= c;
    cond_target_imm <= i;
  endtask : branch
endmodule : aaf_dec_model
`default_nettype wire

// ===== tb/accumulator_alu_with_flags_bench.sv
// self-checking bench for the accumulator alu
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module accumulator_alu_with_flags_bench
  import aaf_pkg::*;
;
  logic        mclk;
  logic        rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        op_valid;
  aaf_op_t     op_code;
  logic [15:0] op_src;
  logic        op_src_is_acc;
  logic [3:0]  op_bit;
  logic        op_imm_bit;
  aaf_cond_t   cond_sel;
  logic        cond_target_imm;
  logic        cond_met;
  logic        op_error;
  logic [15:0] active_acc;
  logic [3:0]  accumulator_selector;
  logic        sign_flag;
  logic        zero_flag;
  logic        carry_flag;
  logic        equals_flag;
  int          err_count;
  int          check_count;
  logic [15:0] ea;
  logic        ec;
  logic        eq;
  aaf_alu uut (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .op_valid, .op_code, .op_src, .op_src_is_acc, .op_bit, .op_imm_bit,
    .cond_sel, .cond_target_imm, .cond_met, .op_error, .active_acc, .accumulator_selector, .sign_flag,
    .zero_flag, .carry_flag, .equals_flag);
  aaf_dec_model dec (.mclk, .op_valid, .op_code, .op_src, .op_src_is_acc, .op_bit, .op_imm_bit,
    .cond_sel, .cond_target_imm);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic final_report();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge mclk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= ad;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      final_report();
    end
  endtask : bus
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ad, d, x);
  endtask : wr
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, ad, 32'h0000_0000, x);
    `CHK(x, e)
  endtask : rchk
  // expected {carry, accumulator} after one operation
  function automatic logic [16:0] rf(input aaf_op_t o, input logic [15:0] a, input logic [15:0] s,
                                     input logic c, input logic [3:0] b, input logic i);
    logic [16:0] r;
    r = {c, a};
    case (o)
      OP_ADD: r = {1'b0, a} + {1'b0, s};
      OP_ADDC: r = {1'b0, a} + {1'b0, s} + {16'h0000, c};
      OP_SUB: r = {1'b0, a} - {1'b0, s};
      OP_SUBB: r = {1'b0, a} - {1'b0, s} - {16'h0000, c};
      OP_AND: r[15:0] = a & s;
      OP_OR: r[15:0] = a | s;
      OP_XOR: r[15:0] = a ^ s;
      OP_CPL: r[15:0] = ~a;
      OP_NEG: r[15:0] = ~a + 16'h0001;
      OP_RL: r[15:0] = {a[14:0], a[15]};
      OP_RLC: r = {a, c};
      OP_RR: r[15:0] = {a[0], a[15:1]};
      OP_RRC: r = {a[0], c, a[15:1]};
      OP_SLA: r = {a, 1'b0};
      OP_SLA2: r = {a[14:0], 2'b00};
      OP_SLA4: r = {a[12:0], 4'h0};
      OP_SRA: r = {a[0], a[15], a[15:1]};
      OP_SRA2: r = {a[1], {2{a[15]}}, a[15:2]};
      OP_SRA4: r = {a[3], {4{a[15]}}, a[15:4]};
      OP_LOGICAL_SHIFT_RIGHT: r = {a[0], 1'b0, a[15:1]};
      OP_XCHN: r[15:0] = {a[11:8], a[15:12], a[3:0], a[7:4]};
      OP_XCH: r[15:0] = {a[7:0], a[15:8]};
      OP_MOV_TO_ACC: r[15:0] = s;
      OP_BIT_TO_C: r[16] = a[b];
      OP_C_TO_BIT: r[b] = c;
      OP_BIT_AND: r[16] = c & a[b];
      OP_BIT_OR: r[16] = c | a[b];
      OP_BIT_XOR: r[16] = c ^ a[b];
      OP_LOAD_C: r[16] = i;
      OP_CPL_C: r[16] = ~c;
      OP_STATUS_WR: r[16] = s[1];
      default: ;
    endcase
    return r;
  endfunction : rf
  function automatic logic [3:0] nstep(input logic [3:0] p, input int md, input logic dn);
    logic [3:0] m;
    logic [3:0] q;
    m = (md == 0) ? 4'h0 : 4'((1 << md) - 1);
    q = dn ? p - 4'h1 : p + 4'h1;
    return (p & ~m) | (q & m);
  endfunction : nstep
  task automatic run(input aaf_op_t o, input logic [15:0] s, input logic [3:0] b, input logic i);
    logic [16:0] r;
    r = rf(o, ea, s, ec, b, i);
    dec.issue(o, s, 1'b0, b, i);
    @(negedge mclk);
    {ec, ea} = r;
    `CHK(active_acc, ea)
    `CHK(carry_flag, ec)
    `CHK(sign_flag, ea[15])
    `CHK(zero_flag, ea == 16'h0000)
  endtask : run
  initial begin
    int k;
    logic [3:0] s0;
    logic e;
    err_count = 0;
    check_count = 0;
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rchk(8'h08, 32'h0000_0080);
    rchk(8'h00, 32'h0000_0000);
    wr(8'h00, 32'h0000_0002);
    wr(8'h04, 32'h0000_0002);
    for (k = 1; k <= 5; k++)
      dec.issue(OP_ADD, 16'(k), 1'b0, 4'h0, 1'b0);
    rchk(8'h40, 32'h0000_0003);
    rchk(8'h44, 32'h0000_0004);
    rchk(8'h48, 32'h0000_0006);
    rchk(8'h4c, 32'h0000_0002);
    rchk(8'h00, 32'h0000_0003);
    for (k = 0; k < 10; k++) begin
      s0 = (k < 5) ? 4'hf : 4'h8;
      wr(8'h00, {28'h0000_000, s0});
      wr(8'h04, 32'((k / 5) * 64 + k % 5));
      dec.issue(aaf_op_t'(6'(27 + (k + 1) % 5)), 16'h0000, 1'b0, 4'h2, 1'b0);
      dec.issue(OP_MOV_FROM_ACC_IDX, 16'h0000, 1'b0, 4'h0, 1'b0);
      @(negedge mclk);
      `CHK(accumulator_selector, s0)
      dec.issue(OP_MOV_FROM_ACC, 16'h0000, 1'b0, 4'h0, 1'b0);
      @(negedge mclk);
      `CHK(accumulator_selector, nstep(s0, k % 5, k >= 5))
    end
    wr(8'h00, 32'h0000_0000);
    @(negedge mclk);
    `CHK(zero_flag, 1'b0)
    wr(8'h04, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
    ea = 16'h0003;
    ec = 1'b0;
    run(OP_MOV_TO_ACC, 16'hffff, 4'h0, 1'b0);
    run(OP_ADD, 16'h0001, 4'h0, 1'b0);
    run(OP_ADDC, 16'h0000, 4'h0, 1'b0);
    run(OP_SUB, 16'h0002, 4'h0, 1'b0);
    run(OP_SUBB, 16'h0000, 4'h0, 1'b0);
    run(OP_AND, 16'h0ff0, 4'h0, 1'b0);
    run(OP_OR, 16'h8001, 4'h0, 1'b0);
    run(OP_XOR, 16'h5555, 4'h0, 1'b0);
    run(OP_CPL, 16'h0000, 4'h0, 1'b0);
    run(OP_NEG, 16'h0000, 4'h0, 1'b0);
    run(OP_MOV_TO_ACC, 16'hb4c9, 4'h0, 1'b0);
    for (k = 11; k <= 23; k++)
      run(aaf_op_t'(k[5:0]), 16'h0000, 4'h0, 1'b0);
    run(OP_BIT_TO_C, 16'h0000, 4'hf, 1'b0);
    for (k = 27; k <= 31; k++)
      run(aaf_op_t'(k[5:0]), 16'h0000, 4'(k * 3), 1'b0);
    run(OP_LOAD_C, 16'h0000, 4'h0, 1'b1);
    run(OP_LOAD_C, 16'h0000, 4'h0, 1'b0);
    run(OP_CPL_C, 16'h0000, 4'h0, 1'b0);
    run(OP_STATUS_WR, 16'h0001, 4'h0, 1'b0);
    `CHK(equals_flag, 1'b1)
    run(OP_CMP, ~ea, 4'h0, 1'b0);
    `CHK(equals_flag, 1'b0)
    run(OP_CMP, ea, 4'h0, 1'b0);
    `CHK(equals_flag, 1'b1)
    eq = 1'b1;
    dec.issue(OP_ADD, 16'h1111, 1'b1, 4'h0, 1'b0);
    @(negedge mclk);
    `CHK(op_error, 1'b1)
    `CHK(active_acc, ea)
    for (k = 0; k < 14; k++) begin
      dec.branch(aaf_cond_t'(k % 7), k < 7);
      case (k % 7)
        0: e = ec;
        1: e = ~ec;
        2: e = ea == 16'h0000;
        3: e = ea != 16'h0000;
        4: e = ea[15];
        5: e = eq & (k < 7);
        default: e = ~eq & (k < 7);
      endcase
      @(posedge mclk);
      @(negedge mclk);
      `CHK(cond_met, e)
    end
    final_report();
  end
endmodule : accumulator_alu_with_flags_bench
`default_nettype wire
